/* verilog/area_wait_params.svh */
`ifndef AREA_WAIT_PARAMS_SVH
`define AREA_WAIT_PARAMS_SVH

// Register offsets on the plain register port
`define AWC_OFF_ASTATE  4'h0
`define AWC_OFF_WAITA   4'h2
`define AWC_OFF_CASLAT  4'h4

// Reset values
`define AWC_ASTATE_RST  8'hff
`define AWC_WAIT_RST    3'h7
`define AWC_CAS_RST     2'h0

// Field positions in wait_count_upper_a
`define AWC_W7_MSB      14
`define AWC_W7_LSB      12
`define AWC_W6_MSB      10
`define AWC_W6_LSB      8

// Field position of the column-strobe latency
`define AWC_CAS_MSB     1
`define AWC_CAS_LSB     0

// Area numbers that own a wait count field
`define AWC_AREA7       3'h7
`define AWC_AREA6       3'h6

`endif

/* verilog/area_wait_pkg.sv */
package area_wait_pkg;

	typedef enum logic [4:0] {
		ACC_IDLE = 5'h01,
		ACC_T1   = 5'h02,
		ACC_T2   = 5'h04,
		ACC_TW   = 5'h08,
		ACC_T3   = 5'h10
	} acc_state_e;

	typedef struct packed {
		logic [7:0]  ast;
		logic [2:0]  w7;
		logic [2:0]  w6;
		logic [1:0]  cas;
		logic [15:0] rdata;
		acc_state_e  fsm;
		logic [2:0]  wcnt;
		logic [2:0]  area;
		logic        three;
	} ctrl_s;

endpackage

/* verilog/area_access_state_wait_control.sv */
// Strobed register access and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "area_wait_params.svh"

module area_access_state_wait_control #(
	parameter int ADDR_W = 4
) (
	input  wire logic                    clk_i,
	input  wire logic                    rst_n_i,
	input  wire logic [ADDR_W-1:0]       addr_i,
	input  wire logic [15:0]             wdata_i,
	input  wire logic                    wr_i,
	input  wire logic                    rd_i,
	output logic      [15:0]             rdata_o,
	input  wire logic                    acc_req_i,
	input  wire logic [2:0]              acc_area_i,
	output logic                         acc_ready_o,
	output logic                         acc_three_state_o,
	output area_wait_pkg::acc_state_e    acc_state_o,
	output logic                         acc_wait_o,
	output logic                         acc_done_o,
	output logic      [7:0]              area_three_state_o,
	output logic      [2:0]              area7_wait_o,
	output logic      [2:0]              area6_wait_o,
	output logic      [1:0]              cas_latency_o
);
	import area_wait_pkg::*;

	if (ADDR_W < 3) begin : g_addr_check
		$error("ADDR_W too small for the register map");
	end

	ctrl_s r;
	ctrl_s next_r;

	logic          hit_astate;
	logic          hit_waita;
	logic          hit_cas;
	logic [2:0]    acc_wait_load;

	assign hit_astate = (addr_i == ADDR_W'(`AWC_OFF_ASTATE));
	assign hit_waita  = (addr_i == ADDR_W'(`AWC_OFF_WAITA));
	assign hit_cas    = (addr_i == ADDR_W'(`AWC_OFF_CASLAT));

	// Effective wait count of the requested area, taken at accept time
	always_comb begin
		acc_wait_load = 3'h0;
		if (r.ast[acc_area_i]) begin
			if (acc_area_i == `AWC_AREA7) begin
				acc_wait_load = r.w7;
			end else if (acc_area_i == `AWC_AREA6) begin
				acc_wait_load = r.w6;
			end
		end
	end

	always_comb begin
		next_r = r;
		next_r.rdata = 16'h0000;

		if (wr_i) begin
			if (hit_astate) begin
				next_r.ast = wdata_i[7:0];
			end
			// reserved bits are simply never stored
			if (hit_waita) begin
				next_r.w7 = wdata_i[`AWC_W7_MSB:`AWC_W7_LSB];
				next_r.w6 = wdata_i[`AWC_W6_MSB:`AWC_W6_LSB];
			end
			if (hit_cas) begin
				next_r.cas = wdata_i[`AWC_CAS_MSB:`AWC_CAS_LSB];
			end
		end

		if (rd_i) begin
			if (hit_astate) begin
				next_r.rdata[7:0] = r.ast;
			end
			if (hit_waita) begin
				next_r.rdata[`AWC_W7_MSB:`AWC_W7_LSB] = r.w7;
				next_r.rdata[`AWC_W6_MSB:`AWC_W6_LSB] = r.w6;
			end
			if (hit_cas) begin
				next_r.rdata[`AWC_CAS_MSB:`AWC_CAS_LSB] = r.cas;
			end
		end

		unique case (r.fsm)
			ACC_IDLE: begin
				if (acc_req_i) begin
					next_r.area  = acc_area_i;
					next_r.three = r.ast[acc_area_i];
					next_r.wcnt  = acc_wait_load;
					next_r.fsm   = ACC_T1;
				end
			end
			ACC_T1: begin
				next_r.fsm = ACC_T2;
			end
			ACC_T2: begin
				if (!r.three) begin
					next_r.fsm = ACC_IDLE;
				// waits go before the last state
				end else if (r.wcnt != 3'h0) begin
					next_r.fsm = ACC_TW;
				end else begin
					next_r.fsm = ACC_T3;
				end
			end
			ACC_TW: begin
				next_r.wcnt = r.wcnt - 3'h1;
				if (r.wcnt == 3'h1) begin
					next_r.fsm = ACC_T3;
				end
			end
			ACC_T3: begin
				next_r.fsm = ACC_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			// all area bits reset to one
			r.ast   <= `AWC_ASTATE_RST;
			r.w7    <= `AWC_WAIT_RST;
			r.w6    <= `AWC_WAIT_RST;
			r.cas   <= `AWC_CAS_RST;
			r.rdata <= 16'h0000;
			r.fsm   <= ACC_IDLE;
			r.wcnt  <= 3'h0;
			r.area  <= 3'h0;
			r.three <= 1'b0;
		end else begin
			r <= next_r;
		end
	end

	// Register writes taken while an access runs do not disturb it:
	// the count and mode are latched once at accept.
	assign rdata_o            = r.rdata;
	assign acc_ready_o        = (r.fsm == ACC_IDLE);
	assign acc_three_state_o  = r.three;
	assign acc_state_o        = r.fsm;
	assign acc_wait_o         = (r.fsm == ACC_TW);
	assign acc_done_o         = (r.fsm == ACC_T3) || ((r.fsm == ACC_T2) && !r.three);
	assign area_three_state_o = r.ast;
	assign area7_wait_o       = r.w7;
	assign area6_wait_o       = r.w6;
	assign cas_latency_o      = r.cas;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	sequence s_two_tail;
		(r.fsm == ACC_T2) ##1 (r.fsm == ACC_IDLE);
	endsequence

	sequence s_three_tail;
		(r.fsm == ACC_T2) ##1 (r.fsm == ACC_T3) ##1 (r.fsm == ACC_IDLE);
	endsequence

	sequence s_three_wait3;
		(r.fsm == ACC_T2) ##1 (r.fsm == ACC_TW) [*3] ##1 (r.fsm == ACC_T3);
	endsequence

	a_two_state_len: assert property (
		(r.fsm == ACC_T1) && !r.three |=> s_two_tail)
		else $error("2-state access not two states");

	a_two_no_wait: assert property (
		!r.three |-> !acc_wait_o)
		else $error("wait state in a 2-state access");

	a_three_state_len: assert property (
		(r.fsm == ACC_T1) && r.three && (r.wcnt == 3'h0) |=> s_three_tail)
		else $error("3-state access not three states");

	a_wait_three: assert property (
		(r.fsm == ACC_T1) && r.three && (r.wcnt == 3'h3) |=> s_three_wait3)
		else $error("three waits not placed before last state");

	a_ast_reset: assert property (
		$past(!rst_n_i) |-> (area_three_state_o == `AWC_ASTATE_RST))
		else $error("area bits not one after reset");

	a_area7_load: assert property (
		acc_ready_o && acc_req_i && (acc_area_i == `AWC_AREA7)
		|=> r.wcnt == ($past(r.ast[7]) ? $past(r.w7) : 3'h0))
		else $error("area 7 wait count wrong");

	a_area6_load: assert property (
		acc_ready_o && acc_req_i && (acc_area_i == `AWC_AREA6)
		|=> r.wcnt == ($past(r.ast[6]) ? $past(r.w6) : 3'h0))
		else $error("area 6 wait count wrong");

	a_wait_write: assert property (
		wr_i && hit_waita |=> rd_i && hit_waita
		|=> rdata_o[`AWC_W7_MSB:`AWC_W7_LSB] == $past(wdata_i[`AWC_W7_MSB:`AWC_W7_LSB], 2))
		else $error("area 7 field not read back");

	a_reserved_zero: assert property (
		rd_i && hit_waita |=> (rdata_o[15] == 1'b0) && (rdata_o[11] == 1'b0))
		else $error("reserved bit read as one");

	a_cas_read: assert property (
		rd_i && hit_cas |=> rdata_o == {14'h0000, $past(r.cas)})
		else $error("latency readback wrong");

endmodule

/* sim/ext_area_model.sv */
`timescale 1ns/1ps
module ext_area_model (
	input  wire logic                     clk_i,
	input  wire logic                     rst_n_i,
	input  wire area_wait_pkg::acc_state_e state_i,
	output int                            len_o,
	output int                            waits_o
);
	import area_wait_pkg::*;
	int cnt;
	int wcnt;
	// count access states
	// Results latch on the first idle cycle, so the bench reads them one cycle late
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			cnt     <= 0;
			wcnt    <= 0;
			len_o   <= 0;
			waits_o <= 0;
		end else if (state_i != ACC_IDLE) begin
			cnt  <= cnt + 1;
			wcnt <= wcnt + int'(state_i == ACC_TW);
		end else if (cnt != 0) begin
			len_o   <= cnt;
			waits_o <= wcnt;
			cnt     <= 0;
			wcnt    <= 0;
		end
	end
endmodule

/* sim/area_access_state_wait_control_bench.sv */
`timescale 1ns/1ps
module area_access_state_wait_control_bench;
	import area_wait_pkg::*;
	logic        clk_i = 0;
	logic        rst_n_i = 0;
	logic [3:0]  addr_i = 4'h0;
	logic [15:0] wdata_i = 16'h0000;
	logic        wr_i = 0;
	logic        rd_i = 0;
	logic        acc_req_i = 0;
	logic [2:0]  acc_area_i = 3'h0;
	logic [15:0] rdata_o;
	logic        acc_ready_o;
	logic        acc_three_state_o;
	acc_state_e  acc_state_o;
	logic        acc_wait_o;
	logic        acc_done_o;
	logic [7:0]  area_three_state_o;
	logic [2:0]  area7_wait_o;
	logic [2:0]  area6_wait_o;
	logic [1:0]  cas_latency_o;
	int          len;
	int          waits;
	int          err_total = 0;
	int          compares = 0;

	area_access_state_wait_control u_dut (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .acc_req_i(acc_req_i),
		.acc_area_i(acc_area_i), .acc_ready_o(acc_ready_o),
		.acc_three_state_o(acc_three_state_o), .acc_state_o(acc_state_o),
		.acc_wait_o(acc_wait_o), .acc_done_o(acc_done_o),
		.area_three_state_o(area_three_state_o), .area7_wait_o(area7_wait_o),
		.area6_wait_o(area6_wait_o), .cas_latency_o(cas_latency_o));

	ext_area_model u_ext (.clk_i(clk_i), .rst_n_i(rst_n_i), .state_i(acc_state_o),
		.len_o(len), .waits_o(waits));

	initial begin
		forever #20 clk_i = ~clk_i;
	end

	task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
		compares++;
		if (s !== e) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_i);
		wr_i    <= 1'b1;
		addr_i  <= a;
		wdata_i <= d;
		@(posedge clk_i);
		wr_i <= 1'b0;
		#1;
	endtask

	task automatic rd(input logic [3:0] a, input logic [15:0] e);
		@(posedge clk_i);
		rd_i   <= 1'b1;
		addr_i <= a;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1;
		chk("rdata", rdata_o, e);
	endtask

	// Write then read with no gap, so the readback sees the fresh field
	task automatic wr_rd(input logic [3:0] a, input logic [15:0] d, input logic [15:0] e);
		@(posedge clk_i);
		wr_i    <= 1'b1;
		addr_i  <= a;
		wdata_i <= d;
		@(posedge clk_i);
		wr_i <= 1'b0;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1;
		chk("rdata_b2b", rdata_o, e);
	endtask

	task automatic acc(input logic [2:0] a, input int n, input logic m);
		int i;
		int d;
		int dn;
		int w;
		d  = 0;
		dn = 0;
		w  = 0;
		@(posedge clk_i);
		acc_req_i  <= 1'b1;
		acc_area_i <= a;
		@(posedge clk_i);
		acc_req_i <= 1'b0;
		#1;
		// Cycle i after accept: done shows once, in the last state only
		for (i = 0; i < 20 && acc_ready_o !== 1'b1; i++) begin
			if (acc_done_o === 1'b1) begin
				d = i;
				dn++;
			end
			w += int'(acc_wait_o === 1'b1);
			@(posedge clk_i);
			#1;
		end
		@(posedge clk_i);
		#1;
		chk("len", 16'(len), m ? 16'(3 + n) : 16'h0002);
		chk("waits", 16'(waits), m ? 16'(n) : 16'h0000);
		chk("mode", {15'h0000, acc_three_state_o}, {15'h0000, m});
		chk("done_at", 16'(d), m ? 16'(2 + n) : 16'h0001);
		chk("done_n", 16'(dn), 16'h0001);
		chk("wait_o", 16'(w), m ? 16'(n) : 16'h0000);
	endtask

	task automatic final_report();
		$display("compares %0d err_total %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial begin
		#100000;
		err_total++;
		final_report();
	end

	initial begin
		repeat (8) @(posedge clk_i);
		rst_n_i <= 1'b1;
		#1;
		chk("ast", {8'h00, area_three_state_o}, 16'h00ff);
		rd(4'h0, 16'h00ff);
		rd(4'h2, 16'h7700);
		wr(4'h2, 16'hffff);
		rd(4'h2, 16'h7700);
		wr_rd(4'h2, 16'h3400, 16'h3400);
		chk("w7", {13'h0000, area7_wait_o}, 16'h0003);
		chk("w6", {13'h0000, area6_wait_o}, 16'h0004);
		rd(4'hf, 16'h0000);
		wr(4'h4, 16'h0003);
		chk("cas", {14'h0000, cas_latency_o}, 16'h0003);
		// Opposite counts in the two fields catch a swapped field
		for (int k = 0; k < 8; k++) begin
			wr(4'h2, {1'b0, 3'(k), 1'b0, 3'(7 - k), 8'h00});
			acc(3'h7, k, 1'b1);
			acc(3'h6, 7 - k, 1'b1);
		end
		acc(3'h2, 0, 1'b1);
		wr(4'h0, 16'h005a);
		rd(4'h0, 16'h005a);
		acc(3'h7, 0, 1'b0);
		acc(3'h6, 0, 1'b1);
		acc(3'h0, 0, 1'b0);
		final_report();
	end
endmodule
